/* File: hdl/msbi_consts.svh */
`ifndef MSBI_CONSTS_SVH
`define MSBI_CONSTS_SVH

`define MSBI_AD_W 16
`define MSBI_LANE_W 8
`define MSBI_STATUS_W 4
`define MSBI_EXT_W 8
`define MSBI_LO_LANE 0
`define MSBI_HI_LANE 8

// Status line codes
`define MSBI_ST_NULL 4'h0
`define MSBI_ST_REFRESH 4'h1
`define MSBI_ST_IO 4'h2
`define MSBI_ST_IRQ_ACK 4'h3

// Reset values
`define MSBI_RST_AD 16'h0000
`define MSBI_RST_OE 16'h0000
`define MSBI_RST_BIT_LO 1'b0
`define MSBI_RST_BIT_HI 1'b1

`endif

/* File: hdl/msbi_pkg.sv */
`include "msbi_consts.svh"

package msbi_pkg;

    typedef enum logic [1:0] {
        MSBI_K_NULL = 2'b00,
        MSBI_K_MEM  = 2'b01,
        MSBI_K_IO   = 2'b10,
        MSBI_K_IACK = 2'b11
    } msbi_kind_t;

    typedef enum logic [2:0] {
        MSBI_S_IDLE  = 3'b000,
        MSBI_S_ADDR  = 3'b001,
        MSBI_S_FETCH = 3'b010,
        MSBI_S_DRIVE = 3'b011,
        MSBI_S_WRITE = 3'b100
    } msbi_state_t;

    // One captured transaction
    typedef struct packed {
        msbi_kind_t kind;
        logic [`MSBI_STATUS_W-1:0] status;
        logic read;
        logic byte_xfer;
        logic [`MSBI_AD_W-1:0] addr;
        logic [`MSBI_EXT_W-1:0] ext;
    } msbi_xact_t;

    // Bus pins as sampled, kept together through one synchroniser
    typedef struct packed {
        logic reset_n;
        logic as_n;
        logic ds_n;
        logic cs_n;
        logic rw;
        logic bw;
        logic ack_n;
        logic grant_in_n;
        logic [`MSBI_STATUS_W-1:0] status;
        logic [`MSBI_AD_W-1:0] ad;
        logic [`MSBI_EXT_W-1:0] ext;
    } msbi_pins_t;

endpackage

/* File: hdl/msbi_sync2.sv */
`timescale 1ns/100ps
`default_nettype none

module msbi_sync2 #(
    parameter int W = 1
) (
    input wire logic i_clk,          // Destination clock
    input wire logic [W-1:0] i_d,    // Asynchronous input
    output logic [W-1:0] o_q         // Synchronised output
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge i_clk) begin
        meta_reg <= i_d;
        q_reg <= meta_reg;
    end

    assign o_q = q_reg;
endmodule // msbi_sync2

`default_nettype wire

/* File: hdl/msbi_event_xfer.sv */
`timescale 1ns/100ps
`default_nettype none

module msbi_event_xfer (
    input wire logic i_src_clk,      // Source clock
    input wire logic i_src_rst,      // Source reset, sync, high
    input wire logic i_src_pulse,    // Event, one source cycle
    input wire logic i_dst_clk,      // Destination clock
    input wire logic i_dst_rst,      // Destination reset, sync, high
    output logic o_dst_pulse         // Event, one destination cycle
);
    logic tog_reg;
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // Toggle survives any ratio; events closer than one
    // destination cycle apart would cancel
    always_ff @(posedge i_src_clk) begin
        if (i_src_rst) begin
            tog_reg <= 1'b0;
        end else if (i_src_pulse) begin
            tog_reg <= ~tog_reg;
        end
    end

    always_ff @(posedge i_dst_clk) begin
        if (i_dst_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= tog_reg;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign o_dst_pulse = sync_reg ^ last_reg;
endmodule // msbi_event_xfer

`default_nettype wire

/* File: hdl/msbi_responder.sv */
`timescale 1ns/100ps
`default_nettype none
`include "msbi_consts.svh"

module msbi_responder
    import msbi_pkg::*;
#(
    parameter bit BUS16 = 1'b1,        // Sixteen data bits on the bus
    parameter bit PERIPH16 = 1'b1,     // This peripheral is 16 bits wide
    parameter bit IS_REQUESTER = 1'b1, // Bus requester part present
    parameter bit USE_ACK_PIN = 1'b1   // Decoded acknowledge pin used
) (
    input wire logic i_clk_sys,                    // System clock
    input wire logic i_sys_rst,                    // System reset
    input wire logic i_bus_clk,                    // Bus clock
    input wire logic i_reset_n,                    // Bus reset pin
    input wire logic i_address_strobe_n,           // Address strobe
    input wire logic i_data_strobe_n,              // Data strobe
    input wire logic i_chip_select_n,              // Decoded select
    input wire logic i_read_write,                 // High = read
    input wire logic i_byte_word,                  // High = byte
    input wire logic [`MSBI_STATUS_W-1:0] i_status, // Status lines
    input wire logic [`MSBI_EXT_W-1:0] i_ext_addr, // Extended address
    input wire logic i_irq_ack_cycle_n,            // Decoded ack pin
    input wire logic [`MSBI_AD_W-1:0] i_muxed_addr_data,  // Lines in
    output logic [`MSBI_AD_W-1:0] o_muxed_addr_data,      // Lines out
    output logic [`MSBI_AD_W-1:0] o_muxed_addr_data_oe,   // Per-line OE
    output logic o_wait_oe,                        // Pulls wait low
    input wire logic i_grant_chain_in_n,           // Chain input
    output logic o_grant_chain_out_n,              // Chain output
    output logic o_master_request_line_oe,         // Pulls request low
    input wire logic i_want_bus,                   // User seeks bus
    input wire logic i_irq_owner,                  // We answer acks
    output logic o_bus_owned,                      // Grant held
    output logic o_bus_reset,                      // Bus reset seen
    output logic o_rd_req,                         // Read request
    output logic o_wr_strobe,                      // Write data valid
    output msbi_pkg::msbi_xact_t o_xact,           // Transaction info
    output logic [`MSBI_AD_W-1:0] o_wr_data,       // Written data
    output logic o_rd_pending,                     // Awaiting answer
    input wire logic i_rd_valid,                   // Answer valid
    input wire logic [`MSBI_AD_W-1:0] i_rd_data    // Answer data
);
    import msbi_pkg::*;

    localparam bit HI_OK = BUS16 && PERIPH16;

    msbi_pins_t pins_raw;
    msbi_pins_t pins_s;
    logic [2:0] from_sys_s;
    logic [1:0] to_sys_s;
    logic sys_rst_l;
    logic want_l;
    logic owner_l;
    logic as_d_reg;
    logic ds_d_reg;
    logic as_rise;
    logic ds_fall;
    logic ds_rise;
    logic strobe_rst;
    logic link_rst;
    logic req_rst;
    logic iack_now;
    msbi_xact_t cap_reg;
    logic cap_sel_reg;
    msbi_state_t state_reg;
    logic [`MSBI_AD_W-1:0] wr_data_reg;
    logic [`MSBI_AD_W-1:0] ad_out_reg;
    logic [`MSBI_AD_W-1:0] ad_oe_reg;
    logic wait_reg;
    logic req_oe_reg;
    logic grant_out_reg;
    logic own_reg;
    logic link_evt;
    logic sys_evt;
    logic resp_evt_sys;
    logic resp_evt_link;
    logic [`MSBI_AD_W-1:0] resp_data_reg;
    logic rd_req_reg;
    logic wr_strobe_reg;
    msbi_xact_t xact_reg;
    logic [`MSBI_AD_W-1:0] wr_out_reg;
    logic pending_reg;

    function automatic msbi_kind_t decode_kind(
        input logic [`MSBI_STATUS_W-1:0] st, input logic ack);
        msbi_kind_t k;
        k = MSBI_K_MEM;
        if (ack) begin
            k = MSBI_K_IACK;
        end else if (st == `MSBI_ST_NULL || st == `MSBI_ST_REFRESH) begin
            k = MSBI_K_NULL;
        end else if (st == `MSBI_ST_IO) begin
            k = MSBI_K_IO;
        end
        return k;
    endfunction

    // All bus pins cross together; the master holds them steady
    assign pins_raw = '{reset_n: i_reset_n, as_n: i_address_strobe_n,
                        ds_n: i_data_strobe_n, cs_n: i_chip_select_n,
                        rw: i_read_write, bw: i_byte_word,
                        ack_n: i_irq_ack_cycle_n,
                        grant_in_n: i_grant_chain_in_n, status: i_status,
                        ad: i_muxed_addr_data, ext: i_ext_addr};

    msbi_sync2 #(.W($bits(msbi_pins_t))) u_pin_sync (
        .i_clk(i_bus_clk),
        .i_d(pins_raw),
        .o_q(pins_s)
    );

    msbi_sync2 #(.W(3)) u_sys_to_link (
        .i_clk(i_bus_clk),
        .i_d({i_sys_rst, i_want_bus, i_irq_owner}),
        .o_q(from_sys_s)
    );
    assign sys_rst_l = from_sys_s[2];
    assign want_l = IS_REQUESTER & from_sys_s[1];
    assign owner_l = from_sys_s[0];

    assign as_rise = pins_s.as_n & ~as_d_reg;
    assign ds_fall = ~pins_s.ds_n & ds_d_reg;
    assign ds_rise = pins_s.ds_n & ~ds_d_reg;
    assign strobe_rst = ~pins_s.as_n & ~pins_s.ds_n;
    assign link_rst = sys_rst_l | ~pins_s.reset_n | strobe_rst;
    assign req_rst = sys_rst_l | ~pins_s.reset_n
                   | (strobe_rst & pins_s.grant_in_n);
    assign iack_now = USE_ACK_PIN ? ~pins_s.ack_n
                    : (pins_s.status == `MSBI_ST_IRQ_ACK);

    always_ff @(posedge i_bus_clk) begin
        if (sys_rst_l) begin
            as_d_reg <= `MSBI_RST_BIT_HI;
            ds_d_reg <= `MSBI_RST_BIT_HI;
        end else begin
            as_d_reg <= pins_s.as_n;
            ds_d_reg <= pins_s.ds_n;
        end
    end

    // Qualifier capture at the start of each transaction
    always_ff @(posedge i_bus_clk) begin
        if (link_rst) begin
            cap_reg <= '0;
            cap_sel_reg <= `MSBI_RST_BIT_LO;
        end else if (as_rise) begin
            cap_reg.kind <= decode_kind(pins_s.status, iack_now);
            cap_reg.status <= pins_s.status;
            cap_reg.read <= pins_s.rw;
            cap_reg.byte_xfer <= BUS16 ? pins_s.bw : 1'b1;
            cap_reg.addr <= pins_s.ad;
            cap_reg.ext <= pins_s.ext;
            // Acks go to the chosen source only, not by select
            cap_sel_reg <= iack_now ? owner_l : ~pins_s.cs_n;
        end
    end

    function automatic logic cap_sel_next();
        return iack_now ? owner_l : ~pins_s.cs_n;
    endfunction

    // A new strobe always restarts, so only one is ever in flight
    always_ff @(posedge i_bus_clk) begin
        if (link_rst) begin
            state_reg <= MSBI_S_IDLE;
        end else if (as_rise) begin
            state_reg <= cap_sel_next() ? MSBI_S_ADDR : MSBI_S_IDLE;
        end else begin
            unique case (state_reg)
                MSBI_S_IDLE: begin
                    state_reg <= MSBI_S_IDLE;
                end
                MSBI_S_ADDR: begin
                    if (ds_fall && cap_reg.kind != MSBI_K_NULL) begin
                        state_reg <= (cap_reg.read
                                      || cap_reg.kind == MSBI_K_IACK)
                                   ? MSBI_S_FETCH : MSBI_S_WRITE;
                    end
                end
                MSBI_S_FETCH: begin
                    if (ds_rise) begin
                        state_reg <= MSBI_S_IDLE;
                    end else if (resp_evt_link) begin
                        state_reg <= MSBI_S_DRIVE;
                    end
                end
                MSBI_S_DRIVE, MSBI_S_WRITE: begin
                    if (ds_rise) begin
                        state_reg <= MSBI_S_IDLE;
                    end
                end
                default: begin
                    state_reg <= MSBI_S_IDLE;
                end
            endcase
        end
    end

    // Write data tracked while data strobe is low, last value kept
    always_ff @(posedge i_bus_clk) begin
        if (link_rst) begin
            wr_data_reg <= `MSBI_RST_AD;
        end else if (state_reg == MSBI_S_WRITE && !pins_s.ds_n) begin
            wr_data_reg <= pins_s.ad;
        end
    end

    // Wait comes three bus clocks after the strobe due to synchronising
    always_ff @(posedge i_bus_clk) begin
        if (link_rst || as_rise) begin
            wait_reg <= `MSBI_RST_BIT_LO;
        end else if (state_reg == MSBI_S_ADDR && ds_fall
                     && cap_reg.kind != MSBI_K_NULL
                     && (cap_reg.read || cap_reg.kind == MSBI_K_IACK)) begin
            wait_reg <= 1'b1;
        end else if (resp_evt_link || ds_rise) begin
            wait_reg <= `MSBI_RST_BIT_LO;
        end
    end

    // Drive only after the master has floated and lowered data strobe
    always_ff @(posedge i_bus_clk) begin
        if (link_rst || as_rise || ds_rise) begin
            ad_oe_reg <= `MSBI_RST_OE;
        end else if (state_reg == MSBI_S_FETCH && resp_evt_link
                     && !pins_s.ds_n) begin
            ad_oe_reg[`MSBI_LO_LANE +: `MSBI_LANE_W] <= '1;
            ad_oe_reg[`MSBI_HI_LANE +: `MSBI_LANE_W] <=
                (HI_OK && !cap_reg.byte_xfer) ? '1 : '0;
        end
    end

    always_ff @(posedge i_bus_clk) begin
        if (link_rst) begin
            ad_out_reg <= `MSBI_RST_AD;
        end else if (state_reg == MSBI_S_FETCH && resp_evt_link) begin
            ad_out_reg <= resp_data_reg;
        end
    end

    // Requester: request line and grant daisy chain
    always_ff @(posedge i_bus_clk) begin
        if (req_rst) begin
            req_oe_reg <= `MSBI_RST_BIT_LO;
            grant_out_reg <= `MSBI_RST_BIT_HI;
            own_reg <= `MSBI_RST_BIT_LO;
        end else begin
            req_oe_reg <= want_l;
            grant_out_reg <= want_l ? 1'b1 : pins_s.grant_in_n;
            own_reg <= want_l & ~pins_s.grant_in_n;
        end
    end

    assign link_evt = (state_reg == MSBI_S_ADDR && ds_fall
                       && cap_reg.kind != MSBI_K_NULL
                       && (cap_reg.read || cap_reg.kind == MSBI_K_IACK))
                    || (state_reg == MSBI_S_WRITE && ds_rise);

    msbi_event_xfer u_req_xfer (
        .i_src_clk(i_bus_clk),
        .i_src_rst(sys_rst_l),
        .i_src_pulse(link_evt),
        .i_dst_clk(i_clk_sys),
        .i_dst_rst(i_sys_rst),
        .o_dst_pulse(sys_evt)
    );

    msbi_event_xfer u_resp_xfer (
        .i_src_clk(i_clk_sys),
        .i_src_rst(i_sys_rst),
        .i_src_pulse(resp_evt_sys),
        .i_dst_clk(i_bus_clk),
        .i_dst_rst(sys_rst_l),
        .o_dst_pulse(resp_evt_link)
    );

    msbi_sync2 #(.W(2)) u_link_to_sys (
        .i_clk(i_clk_sys),
        .i_d({link_rst, own_reg}),
        .o_q(to_sys_s)
    );

    // System side; link registers stay frozen until the answer returns
    assign resp_evt_sys = i_rd_valid & pending_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rd_req_reg <= `MSBI_RST_BIT_LO;
            wr_strobe_reg <= `MSBI_RST_BIT_LO;
            xact_reg <= '0;
            wr_out_reg <= `MSBI_RST_AD;
        end else begin
            rd_req_reg <= sys_evt & (cap_reg.read
                                     | (cap_reg.kind == MSBI_K_IACK));
            wr_strobe_reg <= sys_evt & ~cap_reg.read
                             & (cap_reg.kind != MSBI_K_IACK);
            if (sys_evt) begin
                xact_reg <= cap_reg;
                wr_out_reg <= wr_data_reg;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pending_reg <= `MSBI_RST_BIT_LO;
            resp_data_reg <= `MSBI_RST_AD;
        end else begin
            if (rd_req_reg) begin
                pending_reg <= 1'b1;
            end else if (resp_evt_sys) begin
                pending_reg <= `MSBI_RST_BIT_LO;
            end
            if (resp_evt_sys) begin
                resp_data_reg <= i_rd_data;
            end
        end
    end

    assign o_muxed_addr_data = ad_out_reg;
    assign o_muxed_addr_data_oe = ad_oe_reg;
    assign o_wait_oe = wait_reg;
    assign o_grant_chain_out_n = grant_out_reg;
    assign o_master_request_line_oe = req_oe_reg;
    assign o_bus_owned = to_sys_s[0];
    assign o_bus_reset = to_sys_s[1];
    assign o_rd_req = rd_req_reg;
    assign o_wr_strobe = wr_strobe_reg;
    assign o_xact = xact_reg;
    assign o_wr_data = wr_out_reg;
    assign o_rd_pending = pending_reg;

    default clocking cb @(posedge i_bus_clk); endclocking
    default disable iff (link_rst);

    a_cap_held: assert property (!as_rise |=> $stable(cap_reg))
        else $error("capture changed without address strobe");
    a_addr_capture: assert property (as_rise |=>
        cap_reg.addr == $past(pins_s.ad) && cap_reg.read == $past(pins_s.rw))
        else $error("address or direction not captured");
    a_select_latch: assert property (as_rise && !iack_now |=>
        cap_sel_reg == $past(~pins_s.cs_n))
        else $error("select not latched at address strobe");
    a_wait_on_read: assert property (state_reg == MSBI_S_ADDR && ds_fall
        && cap_reg.read && cap_reg.kind != MSBI_K_NULL |=> wait_reg)
        else $error("wait not raised for read");
    a_wait_no_data: assert property (wait_reg |-> ad_oe_reg == '0)
        else $error("driving data while waiting");
    a_drive_under_ds: assert property ((|ad_oe_reg) |->
        $past(!pins_s.ds_n))
        else $error("driving with data strobe high");
    a_upper_lane: assert property ((!HI_OK || cap_reg.byte_xfer) |->
        ad_oe_reg[`MSBI_HI_LANE +: `MSBI_LANE_W] == '0)
        else $error("upper lane driven on narrow transfer");
    a_null_silent: assert property (cap_reg.kind == MSBI_K_NULL
        && !as_rise |=> ad_oe_reg == '0 && !wait_reg && !link_evt)
        else $error("null transaction moved data");
    a_strobe_reset: assert property (disable iff (1'b0)
        strobe_rst |=> state_reg == MSBI_S_IDLE && ad_oe_reg == '0)
        else $error("both strobes low did not reset");
    a_chain_pass: assert property (disable iff (req_rst)
        !want_l |=> grant_out_reg == $past(pins_s.grant_in_n) && !own_reg)
        else $error("grant chain not passed through");
    a_request_line: assert property (disable iff (req_rst)
        want_l[*2] |-> req_oe_reg)
        else $error("request line not driven");

    c_read_done: cover property (state_reg == MSBI_S_DRIVE ##[1:40] ds_rise);
    c_write_done: cover property (state_reg == MSBI_S_WRITE && ds_rise);
    c_null_seen: cover property (as_rise ##1 cap_reg.kind == MSBI_K_NULL);
    c_iack_seen: cover property (cap_reg.kind == MSBI_K_IACK
                                 && state_reg == MSBI_S_DRIVE);
endmodule // msbi_responder

`default_nettype wire

/* File: tb/msbi_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module msbi_master_model (
    input wire logic i_bus_clk, // Bus clock
    input wire logic i_wait_n, // Wait line, pulled up
    input wire logic [15:0] i_ad, // Resolved lines
    output logic o_as_n, // Address strobe
    output logic o_ds_n, // Data strobe
    output logic o_ad_oe, // Lines driven
    output logic [15:0] o_ad, // Lines out
    output logic o_rw, // High = read
    output logic o_bw, // High = byte
    output logic o_cs_n, // Decoded select
    output logic [3:0] o_status, // Status lines
    output logic [7:0] o_ext // Extended address
);
    initial begin
        o_as_n = 1'b1;
        o_ds_n = 1'b1;
        o_ad_oe = 1'b0;
        o_ad = 16'h0000;
        o_rw = 1'b1;
        o_bw = 1'b0;
        o_cs_n = 1'b1;
        o_status = 4'h0;
        o_ext = 8'h00;
    end
    task automatic strobes(input logic v);
        @(posedge i_bus_clk);
        o_as_n <= v;
        o_ds_n <= v;
    endtask
    task automatic xact(input logic [3:0] st, input logic rd, bw, cs_n, ds,
        input logic [15:0] a, d, output logic [15:0] q);
        int n;
        @(posedge i_bus_clk);
        {o_as_n, o_ad_oe, o_ad, o_ext} <= {2'b01, a, a[15:8]};
        {o_status, o_rw, o_bw, o_cs_n} <= {st, rd, bw, cs_n};
        repeat (2) @(posedge i_bus_clk);
        o_as_n <= 1'b1;
        @(posedge i_bus_clk);
        o_ad_oe <= !rd; // Float first on reads
        o_ad <= d;
        @(posedge i_bus_clk);
        o_ds_n <= !ds; // Null keeps it high
        repeat (5) @(posedge i_bus_clk);
        n = 0;
        while (!i_wait_n && n < 200) begin
            @(posedge i_bus_clk);
            n++;
        end
        q = i_ad; // Taken as the strobe rises
        o_ds_n <= 1'b1;
        repeat (4) @(posedge i_bus_clk);
        o_ad_oe <= 1'b0;
    endtask
endmodule // msbi_master_model
`default_nettype wire

/* File: tb/muxed_shared_bus_interface_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module muxed_shared_bus_interface_tb;
    import msbi_pkg::*;
    logic i_clk_sys, i_sys_rst, i_bus_clk, rst_n, want, gin_n, owner, rdv;
    logic as_n, ds_n, m_oe, rw, bw, cs_n, wait_oe, gout_n, req_oe, owned;
    logic bus_rst, rd_req, wr_stb, pend;
    logic [15:0] rd_ans, oe_seen, d_ad, d_oe, wd, m_ad, q;
    logic [3:0] st;
    logic [7:0] ext;
    msbi_xact_t xact, got, exp_x;
    msbi_xact_t exp_q[$];
    int error_cnt = 0, checks = 0, rd_cnt = 0, wr_cnt = 0, cyc = 0;
    integer seed = 32'h8bca4396;
    wire logic [15:0] ad = (d_oe & d_ad) | (~d_oe & (m_ad ^ {16{!m_oe}}));
    wire logic wait_n = !wait_oe;
    msbi_responder msbi_responder_i (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_bus_clk(i_bus_clk), .i_reset_n(rst_n),
        .i_address_strobe_n(as_n), .i_data_strobe_n(ds_n),
        .i_chip_select_n(cs_n), .i_read_write(rw), .i_byte_word(bw),
        .i_status(st), .i_ext_addr(ext), .i_irq_ack_cycle_n(st != 4'h3),
        .i_muxed_addr_data(ad), .o_muxed_addr_data(d_ad),
        .o_muxed_addr_data_oe(d_oe), .o_wait_oe(wait_oe),
        .i_grant_chain_in_n(gin_n), .o_grant_chain_out_n(gout_n),
        .o_master_request_line_oe(req_oe), .i_want_bus(want),
        .i_irq_owner(owner), .o_bus_owned(owned), .o_bus_reset(bus_rst),
        .o_rd_req(rd_req), .o_wr_strobe(wr_stb), .o_xact(xact),
        .o_wr_data(wd), .o_rd_pending(pend), .i_rd_valid(rdv),
        .i_rd_data(rd_ans));
    msbi_master_model msbi_master_model_i (.i_bus_clk(i_bus_clk),
        .i_wait_n(wait_n), .i_ad(ad), .o_as_n(as_n), .o_ds_n(ds_n),
        .o_ad_oe(m_oe), .o_ad(m_ad), .o_rw(rw), .o_bw(bw), .o_cs_n(cs_n),
        .o_status(st), .o_ext(ext));
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = !i_clk_sys;
    end
    initial begin
        i_bus_clk = 1'b0;
        #13;
        forever #40 i_bus_clk = !i_bus_clk;
    end
    always @(negedge i_clk_sys) begin
        oe_seen = oe_seen | d_oe;
        rdv = pend && !rdv;
        if (rd_req === 1'b1) begin
            got = xact;
            rd_cnt++;
        end
        if (wr_stb === 1'b1) begin
            got = xact;
            wr_cnt++;
        end
        if (rd_req === 1'b1 || wr_stb === 1'b1) begin
            `CHK("expected", 1'b1, exp_q.size() > 0)
            exp_x = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
            `CHK("xact", exp_x, xact)
        end
    end
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task give_verdict;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_x(input logic [3:0] s, input logic r, b, c, ds, hit,
        input msbi_kind_t k);
        logic [15:0] a, d, e;
        int r0, w0;
        a = 16'($random(seed));
        d = 16'($random(seed));
        if (hit) exp_q.push_back(msbi_xact_t'{k, s, r, b, a, a[15:8]});
        rd_ans = d;
        r0 = rd_cnt;
        w0 = wr_cnt;
        oe_seen = 16'h0;
        msbi_master_model_i.xact(s, r, b, c, ds, a, d, q);
        repeat (20) @(negedge i_clk_sys);
        e = (hit && r) ? (b ? 16'h00ff : 16'hffff) : 16'h0;
        `CHK("lanes", e, oe_seen)
        `CHK("reads", r0 + (hit && r), rd_cnt)
        `CHK("writes", w0 + (hit && !r), wr_cnt)
        if (hit) begin
            `CHK("kind", k, got.kind)
            `CHK("status", s, got.status)
            `CHK("addr", a, got.addr)
            `CHK("ext", a[15:8], got.ext)
            `CHK("dir", r, got.read)
            `CHK("width", b, got.byte_xfer)
            e = r ? q : wd;
            `CHK("data", b ? d[7:0] : d, b ? e[7:0] : e)
        end
    endtask
    initial begin
        {i_sys_rst, rst_n, want, gin_n, owner, rdv} = 6'b110110;
        rd_ans = 16'h0;
        oe_seen = 16'h0;
        repeat (10) @(negedge i_clk_sys);
        i_sys_rst = 1'b0;
        repeat (20) @(negedge i_clk_sys);
        do_x(4'h8, 0, 0, 0, 1, 1, MSBI_K_MEM);
        do_x(4'h8, 1, 0, 0, 1, 1, MSBI_K_MEM);
        do_x(4'h2, 1, 1, 0, 1, 1, MSBI_K_IO);
        do_x(4'h2, 0, 1, 0, 1, 1, MSBI_K_IO);
        do_x(4'h8, 1, 0, 1, 1, 0, MSBI_K_MEM);
        do_x(4'h0, 1, 0, 0, 0, 0, MSBI_K_NULL);
        do_x(4'h8, 1, 0, 0, 0, 0, MSBI_K_MEM);
        do_x(4'h3, 1, 1, 1, 1, 1, MSBI_K_IACK);
        msbi_master_model_i.strobes(1'b0);
        repeat (16) @(negedge i_clk_sys);
        `CHK("strobe reset", 1'b1, bus_rst)
        msbi_master_model_i.strobes(1'b1);
        repeat (16) @(negedge i_clk_sys);
        `CHK("reset end", 1'b0, bus_rst)
        rst_n = 1'b0;
        repeat (16) @(negedge i_clk_sys);
        `CHK("pin reset", 1'b1, bus_rst)
        rst_n = 1'b1;
        want = 1'b1;
        repeat (16) @(negedge i_clk_sys);
        `CHK("request", 1'b1, req_oe)
        `CHK("chain held", 1'b1, gout_n)
        `CHK("not owned", 1'b0, owned)
        gin_n = 1'b0;
        repeat (16) @(negedge i_clk_sys);
        `CHK("owned", 1'b1, owned)
        want = 1'b0;
        repeat (16) @(negedge i_clk_sys);
        `CHK("released", 1'b0, req_oe)
        `CHK("chain pass", 1'b0, gout_n)
        `CHK("queue left", 0, exp_q.size())
        give_verdict();
    end
endmodule // muxed_shared_bus_interface_tb
`default_nettype wire
